// file: rtl/monitor_defines.vh
// constants shared by the position coordinate monitor files
// assumes inclusion by bare name from files under rtl/
`ifndef MONITOR_DEFINES_VH
`define MONITOR_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SEL_OFFSET      8'h00
`define FREQ_OFFSET     8'h04
`define STAT_OFFSET     8'h08

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SEL0_LSB        0
`define SEL1_LSB        4
`define SRC_LSB         8
`define SEL0_RESET      4'h1
`define SEL1_RESET      4'h8
`define SRC_RESET       2'h0
`define FREQ_RESET      14'h0064
`define FREQ_MIN        14'h0001
`define FREQ_MAX        14'h2710

// ----------------------------------------
// data selector codes
// ----------------------------------------
`define SEL_ALARM       4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ          10000000
`define PULSE_UNIT_HZ   100
`define PHASES_PER_PULSE 4

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: rtl/sync2.v
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from outside the core_clk domain
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rstn,
  // levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// file: rtl/phase_rate_gen.v
// phase-step rate generator: one tick per quadrature edge
// assumes inc is below CLK_HZ so at most one tick per cycle
`timescale 1ns/1ps
module phase_rate_gen #(
  parameter ACC_W  = 24,
  parameter CLK_HZ = 10000000
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // control
  input  wire             run,
  input  wire [ACC_W-1:0] inc,
  output reg              tick
);

  localparam [ACC_W-1:0] LIMIT = CLK_HZ[ACC_W-1:0];

  reg  [ACC_W:0] acc_r;
  wire [ACC_W:0] sum = acc_r + {1'b0, inc};

  // accumulator keeps the remainder, so the average rate is exact; single gaps can run a cycle short
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= {(ACC_W+1){1'b0}};
      tick  <= 1'b0;
    end else if (!run) begin
      acc_r <= {(ACC_W+1){1'b0}};
      tick  <= 1'b0;
    end else if (sum >= {1'b0, LIMIT}) begin
      acc_r <= sum - {1'b0, LIMIT};
      tick  <= 1'b1;
    end else begin
      acc_r <= sum;
      tick  <= 1'b0;
    end
  end

endmodule

// file: rtl/position_coordinate_monitor.v
// position coordinate monitor: serial shift-out and quadrature replay
// assumes positions, alarm and live encoder phases come from core_clk logic
//
// Behaviour
// - request rise snapshots positions and alarm and raises serial output in the same cycle
// - each shift clock rising edge presents the next bit
// - every field goes out least significant bit first
// - alarm selection sends the active alarm code as 8 bits
// - combined selection sends 32-bit position then 8-bit alarm
// - checksum is low 8 bits of the sum of all data bytes
// - dropping the request early abandons the rest of the transfer
// - replay request freezes phase outputs and records positions
// - shift clock high starts replay; ready drops when done
// - replay source 0 cmd, 1 cmd counter, 2 fb, 3 fb counter
// - max frequency 1..10000 in 0.1 kHz, default 100, never exceeded
// - each position field is 32 bits
// - positions are two's complement
// - checksum byte goes last
// - per-request selectors: 1-4 position, 8 alarm, 9-12 both
`timescale 1ns/1ps
`include "monitor_defines.vh"
module position_coordinate_monitor (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // axi4-lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // host pins
  input  wire        monitor_request_first,
  input  wire        monitor_request_second,
  input  wire        monitor_shift_clock,
  input  wire        pulse_replay_request,
  output reg         serial_monitor_output,
  output reg         pulse_replay_ready,
  output reg         quadrature_phase_a_out,
  output reg         quadrature_phase_b_out,
  // position sources
  input  wire [31:0] cmd_pos,
  input  wire [31:0] cmd_pos_counter,
  input  wire [31:0] fb_pos,
  input  wire [31:0] fb_pos_counter,
  input  wire [7:0]  alarm_code,
  input  wire        enc_a_live,
  input  wire        enc_b_live
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [31:0] pick4;
    input [1:0]  idx;
    input [31:0] v0, v1, v2, v3;
    begin
      case (idx)
        2'h0:    pick4 = v0;
        2'h1:    pick4 = v1;
        2'h2:    pick4 = v2;
        default: pick4 = v3;
      endcase
    end
  endfunction

  function [7:0] byte_sum;
    input [31:0] v;
    begin
      byte_sum = v[7:0] + v[15:8] + v[23:16] + v[31:24];
    end
  endfunction

  function [31:0] merge_strb;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      merge_strb = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k]) merge_strb[k*8 +: 8] = data[k*8 +: 8];
    end
  endfunction

  // quadrature step index to phase pair {a,b}
  function [1:0] ab_of;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    ab_of = 2'h0;
        2'h1:    ab_of = 2'h2;
        2'h2:    ab_of = 2'h3;
        default: ab_of = 2'h1;
      endcase
    end
  endfunction

  // phase pair {a,b} back to quadrature step index
  function [1:0] idx_of;
    input [1:0] ab;
    begin
      idx_of = {ab[0], ab[1] ^ ab[0]};
    end
  endfunction

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg [3:0]  sel0_r;
  reg [3:0]  sel1_r;
  reg [1:0]  src_r;
  reg [13:0] freq_r;
  reg [7:0]  aw_addr_r;
  reg        aw_hold_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  reg        w_hold_r;

  wire [31:0] sel_word  = {22'h0, src_r, sel1_r, sel0_r};
  wire [31:0] freq_word = {18'h0, freq_r};
  wire [31:0] new_sel   = merge_strb(sel_word, w_data_r, w_strb_r);
  wire [31:0] new_freq  = merge_strb(freq_word, w_data_r, w_strb_r);

  // address and data taken in either order; response after both
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      sel0_r        <= `SEL0_RESET;
      sel1_r        <= `SEL1_RESET;
      src_r         <= `SRC_RESET;
      freq_r        <= `FREQ_RESET;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_hold_r & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_hold_r & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_hold_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_hold_r <= 1'b1;
      end
      if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (aw_addr_r == `SEL_OFFSET) begin
          sel0_r <= new_sel[`SEL0_LSB +: 4];
          sel1_r <= new_sel[`SEL1_LSB +: 4];
          src_r  <= new_sel[`SRC_LSB +: 2];
        end else if (aw_addr_r == `FREQ_OFFSET) begin
          // out-of-range settings are clamped so the rate stays defined
          if (new_freq[13:0] < `FREQ_MIN || new_freq[31:14] != 18'h0)
            freq_r <= (new_freq[31:14] != 18'h0) ? `FREQ_MAX : `FREQ_MIN;
          else if (new_freq[13:0] > `FREQ_MAX)
            freq_r <= `FREQ_MAX;
          else
            freq_r <= new_freq[13:0];
        end else if (aw_addr_r != `STAT_OFFSET) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  wire [3:0] pins_s;
  reg  [3:0] pins_d_r;

  sync2 #(.W(4)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({pulse_replay_request, monitor_shift_clock,
                monitor_request_second, monitor_request_first}),
    .sync_out (pins_s)
  );

  wire req0_s  = pins_s[0];
  wire req1_s  = pins_s[1];
  wire sclk_s  = pins_s[2];
  wire preq_s  = pins_s[3];
  wire req0_on = req0_s & ~pins_d_r[0];
  wire req1_on = req1_s & ~pins_d_r[1];
  wire sclk_on = sclk_s & ~pins_d_r[2];
  wire preq_on = preq_s & ~pins_d_r[3];

  // edge history reads only synchronised levels
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) pins_d_r <= 4'h0;
    else       pins_d_r <= pins_s;
  end

  // ----------------------------------------
  // serial frame builder
  // ----------------------------------------
  reg  [3:0]  code;
  reg         has_pos;
  reg         has_alm;
  reg  [31:0] pos_v;
  reg  [47:0] frame_nxt;
  reg  [5:0]  len_nxt;
  wire [1:0]  pidx = code[1:0] - 2'h1;

  // unknown codes fall back to alarm only
  always @* begin
    code    = req0_on ? sel0_r : sel1_r;
    has_pos = (code >= 4'h1 && code <= 4'h4) || (code >= 4'h9 && code <= 4'hC);
    has_alm = !(code >= 4'h1 && code <= 4'h4);
    pos_v   = pick4(pidx, fb_pos, fb_pos_counter, cmd_pos, cmd_pos_counter);
    if (has_pos && has_alm) begin
      frame_nxt = {byte_sum(pos_v) + alarm_code, alarm_code, pos_v};
      len_nxt   = 6'd48;
    end else if (has_pos) begin
      frame_nxt = {8'h00, byte_sum(pos_v), pos_v};
      len_nxt   = 6'd40;
    end else begin
      frame_nxt = {32'h0, alarm_code, alarm_code};
      len_nxt   = 6'd16;
    end
  end

  // ----------------------------------------
  // serial shift-out
  // ----------------------------------------
  reg        ser_act_r;
  reg        ser_src_r;
  reg [47:0] frame_r;
  reg [5:0]  left_r;
  wire       owner_s = ser_src_r ? req1_s : req0_s;

  // a second request while busy is ignored; the owner's drop ends it
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ser_act_r             <= 1'b0;
      ser_src_r             <= 1'b0;
      frame_r               <= 48'h0;
      left_r                <= 6'd0;
      serial_monitor_output <= 1'b0;
    end else if (!ser_act_r) begin
      if (req0_on || req1_on) begin
        ser_act_r             <= 1'b1;
        ser_src_r             <= ~req0_on;
        frame_r               <= frame_nxt;
        left_r                <= len_nxt;
        serial_monitor_output <= 1'b1;
      end
    end else if (!owner_s) begin
      ser_act_r             <= 1'b0;
      left_r                <= 6'd0;
      serial_monitor_output <= 1'b0;
    end else if (sclk_on) begin
      // host paces bits; each edge is far apart at the allowed rate
      if (left_r != 6'd0) begin
        serial_monitor_output <= frame_r[0];
        frame_r               <= {1'b0, frame_r[47:1]};
        left_r                <= left_r - 6'd1;
      end else begin
        serial_monitor_output <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pulse replay
  // ----------------------------------------
  localparam [1:0] P_IDLE = 2'h0;
  localparam [1:0] P_WAIT = 2'h1;
  localparam [1:0] P_RUN  = 2'h2;
  localparam [1:0] P_DONE = 2'h3;
  localparam integer STEP_SCALE_I = `PULSE_UNIT_HZ * `PHASES_PER_PULSE;
  localparam [23:0]  STEP_SCALE   = STEP_SCALE_I[23:0];

  reg  [1:0]  pstate_r;
  reg  [1:0]  qidx_r;
  reg         dir_neg_r;
  reg  [34:0] steps_r;
  wire        tick;
  wire [31:0] rep_v  = pick4(src_r, cmd_pos, cmd_pos_counter, fb_pos, fb_pos_counter);
  wire [32:0] rep_mag = rep_v[31] ? (33'h0 - {rep_v[31], rep_v}) : {1'b0, rep_v};
  wire [23:0] rate_inc = {10'h000, freq_r} * STEP_SCALE;
  wire [1:0]  qidx_nxt = dir_neg_r ? qidx_r - 2'h1 : qidx_r + 2'h1;
  wire [1:0]  live_idx = idx_of({enc_a_live, enc_b_live});

  phase_rate_gen #(.ACC_W(24), .CLK_HZ(`CLK_HZ)) u_rate (
    .core_clk (core_clk),
    .rstn     (rstn),
    .run      (pstate_r == P_RUN),
    .inc      (rate_inc),
    .tick     (tick)
  );

  // outputs track the live encoder only while idle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pstate_r               <= P_IDLE;
      qidx_r                 <= 2'h0;
      dir_neg_r              <= 1'b0;
      steps_r                <= 35'h0;
      pulse_replay_ready     <= 1'b0;
      quadrature_phase_a_out <= 1'b0;
      quadrature_phase_b_out <= 1'b0;
    end else begin
      case (pstate_r)
        P_IDLE: begin
          if (preq_on) begin
            pstate_r           <= P_WAIT;
            qidx_r             <= idx_of({quadrature_phase_a_out, quadrature_phase_b_out});
            dir_neg_r          <= rep_v[31];
            steps_r            <= {rep_mag, 2'b00};
            pulse_replay_ready <= 1'b1;
          end else begin
            // phases hold on the request edge so the index matches them
            quadrature_phase_a_out <= enc_a_live;
            quadrature_phase_b_out <= enc_b_live;
          end
        end
        P_WAIT: begin
          if (!preq_s) begin
            pstate_r           <= P_IDLE;
            pulse_replay_ready <= 1'b0;
          end else if (sclk_s) begin
            // zero position has nothing to send
            if (steps_r == 35'h0) begin
              pstate_r           <= P_DONE;
              pulse_replay_ready <= 1'b0;
            end else begin
              pstate_r <= P_RUN;
            end
          end
        end
        P_RUN: begin
          if (!preq_s) begin
            pstate_r           <= P_IDLE;
            pulse_replay_ready <= 1'b0;
          end else if (tick) begin
            qidx_r                 <= qidx_nxt;
            {quadrature_phase_a_out, quadrature_phase_b_out} <= ab_of(qidx_nxt);
            steps_r                <= steps_r - 35'h1;
            if (steps_r == 35'h1) begin
              pstate_r           <= P_DONE;
              pulse_replay_ready <= 1'b0;
            end
          end
        end
        default: begin
          // host watches ready low before release
          if (!preq_s) pstate_r <= P_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  wire [31:0] stat_word = {24'h0, 2'h0, pstate_r, live_idx == qidx_r,
                           pulse_replay_ready, serial_monitor_output, ser_act_r};

  // one request at a time; data one cycle after the address is taken
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `SEL_OFFSET:  s_axi_rdata <= sel_word;
          `FREQ_OFFSET: s_axi_rdata <= freq_word;
          `STAT_OFFSET: s_axi_rdata <= stat_word;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: test/mon_checker.sv
// checker: serial monitor and quadrature replay timing at the top ports
// assumes binding onto the monitor top, single core_clk domain
`timescale 1ns/1ps
module mon_checker (
  // clock and reset
  input logic       core_clk,
  input logic       rstn,
  // bus write answer
  input logic       s_axi_bvalid,
  input logic [1:0] s_axi_bresp,
  // host pins
  input logic       monitor_request_first,
  input logic       monitor_request_second,
  input logic       monitor_shift_clock,
  input logic       pulse_replay_request,
  input logic       serial_monitor_output,
  input logic       pulse_replay_ready,
  input logic       quadrature_phase_a_out,
  input logic       quadrature_phase_b_out
);
  // pins pass two flops and an edge flop, so windows allow about six cycles
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  wire req = monitor_request_first | monitor_request_second;
  wire qa  = quadrature_phase_a_out;
  wire qb  = quadrature_phase_b_out;

  a_serial_arm: assert property ($rose(monitor_request_first) && !monitor_request_second && !serial_monitor_output
    |-> ##[1:6] serial_monitor_output) else $error("serial ready flag late");
  a_serial_owner: assert property ($rose(serial_monitor_output) |-> req)
    else $error("serial output rose without a request");
  a_serial_idle: assert property ((!req)[*8] |-> !serial_monitor_output)
    else $error("serial output high with no request");
  a_bit_on_clock: assert property ($stable({monitor_shift_clock, monitor_request_first, monitor_request_second})[*7]
    |=> $stable(serial_monitor_output)) else $error("serial bit moved without a clock edge");
  a_replay_arm: assert property ($rose(pulse_replay_request) |-> ##[1:6] pulse_replay_ready)
    else $error("replay ready late");
  a_replay_abort: assert property ((!pulse_replay_request)[*8] |-> !pulse_replay_ready)
    else $error("replay ready without request");
  a_replay_frozen: assert property ((pulse_replay_ready && !monitor_shift_clock)[*4] |=> $stable(qa) && $stable(qb))
    else $error("phases moved while frozen");
  a_replay_pace: assert property (pulse_replay_ready && ($changed(qa) || $changed(qb)) |=> $stable(qa) && $stable(qb))
    else $error("replay steps too close");
  a_replay_gray: assert property (pulse_replay_ready |-> !($changed(qa) && $changed(qb)))
    else $error("both phases changed together");
  a_done_hold: assert property ($fell(pulse_replay_ready) && pulse_replay_request |=> ($stable(qa) && $stable(qb))[*3])
    else $error("phases moved after replay end");

  c_frame: cover property ($rose(serial_monitor_output));
  c_replay: cover property ($fell(pulse_replay_ready) && pulse_replay_request);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind position_coordinate_monitor mon_checker u_chk (.core_clk, .rstn, .s_axi_bvalid, .s_axi_bresp,
  .monitor_request_first, .monitor_request_second, .monitor_shift_clock, .pulse_replay_request,
  .serial_monitor_output, .pulse_replay_ready, .quadrature_phase_a_out, .quadrature_phase_b_out);

// file: test/host_model.sv
// host model: serial monitor reader and quadrature edge counter
// assumes its tasks are called one at a time from the testbench
`timescale 1ns/1ps
module host_model (
  // clock
  input  logic core_clk,
  // pins from the device
  input  logic serial_monitor_output,
  input  logic pulse_replay_ready,
  input  logic quadrature_phase_a_out,
  input  logic quadrature_phase_b_out,
  // pins to the device
  output logic monitor_request_first  = 1'b0,
  output logic monitor_request_second = 1'b0,
  output logic monitor_shift_clock    = 1'b0,
  output logic pulse_replay_request   = 1'b0
);
  int   edges = 0;
  int   base  = 0;
  logic pa    = 1'b0;
  logic pb    = 1'b0;

  // a change whose old a equals the new b is a forward step
  always @(posedge core_clk) begin
    if ({quadrature_phase_a_out, quadrature_phase_b_out} != {pa, pb})
      edges <= edges + ((pa == quadrature_phase_b_out) ? 1 : -1);
    pa <= quadrature_phase_a_out;
    pb <= quadrature_phase_b_out;
  end

  // link clock runs only inside a frame, 800 ns period
  task automatic serial(input logic second, input int n, output logic [47:0] got);
    got = 48'h0;
    if (second) monitor_request_second <= 1'b1;
    else monitor_request_first <= 1'b1;
    do @(posedge core_clk); while (serial_monitor_output !== 1'b1);
    for (int i = 0; i < n; i++) begin
      monitor_shift_clock <= 1'b1;
      repeat (4) @(posedge core_clk);
      monitor_shift_clock <= 1'b0;
      repeat (4) @(posedge core_clk);
      got[i] = serial_monitor_output;
    end
    monitor_request_first <= 1'b0;
    monitor_request_second <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic arm();
    pulse_replay_request <= 1'b1;
    do @(posedge core_clk); while (pulse_replay_ready !== 1'b1);
    base = edges;
  endtask

  task automatic fire(output int cyc);
    cyc = 0;
    monitor_shift_clock <= 1'b1;
    do begin
      @(posedge core_clk);
      cyc++;
    end while (pulse_replay_ready === 1'b1);
    monitor_shift_clock <= 1'b0;
    pulse_replay_request <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// file: test/position_coordinate_monitor_tb.sv
// testbench: register access, serial frames and quadrature replays
// assumes host_model drives the host pins and counts phase edges
`timescale 1ns/1ps
module position_coordinate_monitor_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         req1, req2, sclk, preq, sout, prdy, qa, qb;
  // cmd counter, fb, fb counter, cmd
  logic [31:0] pos [4] = '{32'h000002BC, 32'h0000012C, 32'hFFFFFFCE, 32'hFFFFFED4};
  logic [7:0]  alarm = 8'h66;
  logic [1:0]  live = 2'h0;
  int          fail_count = 0;
  int          checks_done = 0;

  always #50 core_clk = ~core_clk;

  position_coordinate_monitor DUT (.core_clk, .rstn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .monitor_request_first(req1),
    .monitor_request_second(req2), .monitor_shift_clock(sclk), .pulse_replay_request(preq),
    .serial_monitor_output(sout), .pulse_replay_ready(prdy), .quadrature_phase_a_out(qa),
    .quadrature_phase_b_out(qb), .cmd_pos(pos[3]), .cmd_pos_counter(pos[0]), .fb_pos(pos[1]),
    .fb_pos_counter(pos[2]), .alarm_code(alarm), .enc_a_live(live[1]), .enc_b_live(live[0]));

  host_model HOST (.core_clk, .serial_monitor_output(sout), .pulse_replay_ready(prdy),
    .quadrature_phase_a_out(qa), .quadrature_phase_b_out(qb), .monitor_request_first(req1),
    .monitor_request_second(req2), .monitor_shift_clock(sclk), .pulse_replay_request(preq));

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one spare edge at the end keeps back-to-back calls off the same time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", bresp, er);
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // frame bits in arrival order: position, alarm, then checksum
  function automatic logic [47:0] frame(input logic [3:0] c, output int n);
    logic [31:0] p;
    logic [7:0]  s;
    p = pos[c[1:0]];
    s = p[7:0] + p[15:8] + p[23:16] + p[31:24];
    if (c == 4'h8) begin
      n = 16;
      frame = {32'h0, alarm, alarm};
    end else if (c > 4'h8) begin
      n = 48;
      frame = {s + alarm, alarm, p};
    end else begin
      n = 40;
      frame = {8'h0, s, p};
    end
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    logic [47:0] got, exp;
    logic [31:0] sv [4];
    logic [3:0]  codes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    int          n, cyc, v;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h08, 32'h00000008, 2'h0);
    rd(8'h00, 32'h00000081, 2'h0);
    rd(8'h04, 32'h00000064, 2'h0);
    rd(8'h0C, 32'h00000000, 2'h2);
    wr(8'h0C, 32'h00000001, 2'h2);
    wr(8'h08, 32'h00000000, 2'h0);
    wstrb <= 4'h2;
    wr(8'h00, 32'h000003FF, 2'h0);
    wstrb <= 4'hF;
    rd(8'h00, 32'h00000381, 2'h0);
    wr(8'h04, 32'h00000000, 2'h0);
    rd(8'h04, 32'h00000001, 2'h0);
    wr(8'h04, 32'h0000FFFF, 2'h0);
    rd(8'h04, 32'h00002710, 2'h0);
    // abandoned frame first, so the next one proves the pointer restarts
    wr(8'h00, 32'h000000CC, 2'h0);
    exp = frame(4'hC, n);
    HOST.serial(1'b0, 12, got);
    chk("partial", got & 48'hFFF, exp & 48'hFFF);
    for (int i = 0; i < 9; i++) begin
      wr(8'h00, {24'h0, codes[i], codes[i]}, 2'h0);
      exp = frame(codes[i], n);
      sv = pos;
      fork
        HOST.serial(i[0], n, got);
        begin
          repeat (20) @(posedge core_clk);
          pos <= '{4{32'h0}};
          alarm <= 8'h00;
        end
      join
      pos <= sv;
      alarm <= 8'h66;
      chk("frame", got, exp);
    end
    // every replay source; the slower rate shows the pacing limit
    for (int s = 0; s < 4; s++) begin
      wr(8'h04, (s == 3) ? 32'h000003E8 : 32'h00002710, 2'h0);
      wr(8'h00, {22'h0, s[1:0], 8'h81}, 2'h0);
      v = pos[2'(s + 3)];
      HOST.arm();
      repeat (4) begin
        live <= {~live[0], live[1]};
        repeat (3) @(posedge core_clk);
      end
      rd(8'h08, 32'h0000001C, 2'h0);
      chk("frozen", HOST.edges - HOST.base, 0);
      HOST.fire(cyc);
      chk("edges", HOST.edges - HOST.base, 4 * v);
      chk("pace", cyc >= (v < 0 ? -v : v) * ((s == 3) ? 100 : 10) - 2, 1);
    end
    conclude();
  end

  // watchdog sized well above the expected run of about 21500 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule
